// file: include/irq_pkg.sv
// Constants, field layouts and carrier types for the interrupt status, acknowledge and mask block.
// Notes on behaviour
// - Interrupt output is registered: it goes high one clock after any status bit meets its high mask bit.
// - Mask register is reachable as part of a word or as its own byte.
// - Management change flag sets on monitored PHY bit change; cleared by acknowledge.
// - Monitored PHY bits latch on change and refresh to live value when read.
// - Early receive flag sets when stored bytes pass threshold; cleared by acknowledge.
// - Early receive threshold counts in units of 64 bytes.
// - Protocol exception merges link, rollover, fatal transmit sources, each separately enabled.
// - Protocol exception clears by disabling link, reading counter, or setting transmit on.
// - Receive abort flag latches on allocation, length or drop abort; cleared by acknowledge.
// - Allocation flag sets on success, is inverse of failed flag, clears on request or failure.
// - Transmit queue empty flag latches on becoming empty until acknowledged.
// - Transmit completion flag is the inverse of completion queue empty.
// - Host acknowledges completion after service; device removes that entry.
// - Completion acknowledge pops the entry at the completion queue output.
// - Receive flag is inverse of receive queue empty; acknowledge does not clear it.
// - Drop before packet end discards and sets abort flag; later drop receives normally.
// - Drop request clears itself and affects only a packet being received.
package irq_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [5:0] IDX_STATUS = 6'h0C;
    localparam logic [5:0] IDX_MASK = 6'h0D;
    localparam logic [5:0] IDX_EARLY_RX = 6'h0C;
    localparam logic [5:0] IDX_BANK = 6'h0E;
    localparam logic [5:0] IDX_CONTROL = 6'h10;
    localparam logic [5:0] IDX_PHY_STATUS = 6'h11;
    localparam logic [5:0] IDX_COUNTER = 6'h12;
    localparam logic [5:0] IDX_PROTOCOL = 6'h13;
    localparam logic [2:0] BANK_IRQ = 3'h2;
    localparam logic [2:0] BANK_EARLY = 3'h3;
    localparam logic [2:0] BANK_RESET = 3'h0;

    // Status bit positions.
    localparam int B_MGMT = 7;
    localparam int B_EARLY = 6;
    localparam int B_PROTO = 5;
    localparam int B_ABORT = 4;
    localparam int B_ALLOC = 3;
    localparam int B_TXEMPTY = 2;
    localparam int B_TXDONE = 1;
    localparam int B_RX = 0;
    localparam logic [7:0] ACK_CLEARABLE = 8'hD6;
    localparam logic [7:0] STATUS_RESET = 8'h04;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // Early receive control fields.
    localparam int B_DROP = 7;
    localparam int LIMIT_W = 5;
    localparam int UNIT_SHIFT = 6;
    localparam int COUNT_W = 12;

    // Control register fields.
    localparam int B_TX_ON = 0;
    localparam int B_LINK_EN = 1;
    localparam int B_ROLL_EN = 2;
    localparam int B_TXERR_EN = 3;
    localparam logic [3:0] CONTROL_RESET = 4'h0;

    localparam int PHY_W = 9;

    typedef struct packed {
        logic active;
        logic ended;
        logic alloc_abort;
        logic long_abort;
        logic [COUNT_W-1:0] byte_count;
    } rx_event_t;

    typedef struct packed {
        logic underrun;
        logic sqe_fault;
        logic carrier_lost;
        logic late_collision;
        logic excess_collisions;
    } tx_fault_t;

    typedef struct packed {
        logic link_down;
        logic rollover;
        tx_fault_t fault;
    } protocol_cause_t;

endpackage

// file: logic/irq_status_block.sv
// Interrupt status, acknowledge and mask logic with early receive control, behind an APB slave.
module irq_status_block (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receiver
    input wire irq_pkg::rx_event_t rx_event,
    input wire logic rx_queue_empty,
    output logic rx_discard,
    // Transmitter and MMU
    input wire logic alloc_request,
    input wire logic alloc_ok,
    input wire logic alloc_fail,
    output logic alloc_failed,
    input wire logic tx_queue_empty,
    input wire logic completion_queue_empty,
    output logic completion_pop,
    input wire logic link_event,
    input wire logic rollover_event,
    input wire logic tx_fatal,
    input wire irq_pkg::tx_fault_t tx_fault,
    output logic transmit_on,
    // PHY monitored status bits
    input wire logic [irq_pkg::PHY_W-1:0] phy_status_live,
    // Interrupt line
    output logic irq
);

    localparam int COUNT_W_L = irq_pkg::COUNT_W;

    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic [2:0] bank_q;
    logic [7:0] mask_q;
    logic [7:0] early_rx_ctrl_q;
    logic [3:0] control_q;
    logic mgmt_q;
    logic early_q;
    logic early_fired_q;
    logic abort_q;
    logic alloc_q;
    logic txempty_q;
    logic txempty_prev_q;
    logic link_pend_q;
    logic roll_pend_q;
    logic txerr_pend_q;
    logic [irq_pkg::PHY_W-1:0] phy_held_q;
    logic phy_pend_q;
    logic [7:0] rollover_count_q;
    irq_pkg::protocol_cause_t cause_q;
    logic [7:0] status;
    logic [5:0] idx;
    logic setup;
    logic wr;
    logic rd;
    logic hit_status;
    logic hit_mask;
    logic hit_early;
    logic hit_bank;
    logic hit_control;
    logic hit_phy;
    logic hit_counter;
    logic hit_protocol;
    logic mapped;
    logic [7:0] ack;
    logic drop_now;
    logic [COUNT_W_L-1:0] limit_bytes;
    logic over_limit;
    logic tx_on_rise;

    // Bus decode. Accesses complete in one access cycle.
    assign idx = paddr[7:2];
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign hit_status = (idx == irq_pkg::IDX_STATUS) && (bank_q == irq_pkg::BANK_IRQ);
    assign hit_mask = (idx == irq_pkg::IDX_MASK) && (bank_q == irq_pkg::BANK_IRQ);
    assign hit_early = (idx == irq_pkg::IDX_EARLY_RX) && (bank_q == irq_pkg::BANK_EARLY);
    assign hit_bank = (idx == irq_pkg::IDX_BANK);
    assign hit_control = (idx == irq_pkg::IDX_CONTROL);
    assign hit_phy = (idx == irq_pkg::IDX_PHY_STATUS);
    assign hit_counter = (idx == irq_pkg::IDX_COUNTER);
    assign hit_protocol = (idx == irq_pkg::IDX_PROTOCOL);
    assign mapped = hit_status || hit_mask || hit_early || hit_bank || hit_control
        || hit_phy || hit_counter || hit_protocol;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_q;

    // Only clearable positions written high in the low lane act.
    assign ack = (wr && hit_status && pstrb[0]) ? (pwdata[7:0] & irq_pkg::ACK_CLEARABLE)
        : 8'h00;

    // Status byte assembly; two bits follow queue state directly.
    always_comb begin
        status = 8'h00;
        status[irq_pkg::B_MGMT] = mgmt_q;
        status[irq_pkg::B_EARLY] = early_q;
        status[irq_pkg::B_PROTO] = link_pend_q || roll_pend_q || txerr_pend_q;
        status[irq_pkg::B_ABORT] = abort_q;
        status[irq_pkg::B_ALLOC] = alloc_q;
        status[irq_pkg::B_TXEMPTY] = txempty_q;
        status[irq_pkg::B_TXDONE] = !completion_queue_empty;
        status[irq_pkg::B_RX] = !rx_queue_empty;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask_q);
        end
    end

    // Read data is captured in the setup cycle.
    always_comb begin
        prdata_d = 32'h0000_0000;
        if (hit_status) begin
            prdata_d[7:0] = status;
            prdata_d[15:8] = mask_q;
        end else if (hit_mask) begin
            prdata_d[7:0] = mask_q;
        end else if (hit_early) begin
            prdata_d[7:0] = early_rx_ctrl_q;
        end else if (hit_bank) begin
            prdata_d[2:0] = bank_q;
        end else if (hit_control) begin
            prdata_d[3:0] = control_q;
        end else if (hit_phy) begin
            prdata_d[irq_pkg::PHY_W-1:0] = phy_held_q;
        end else if (hit_counter) begin
            prdata_d[7:0] = rollover_count_q;
        end else if (hit_protocol) begin
            prdata_d[6:0] = cause_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_q <= prdata_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            bank_q <= irq_pkg::BANK_RESET;
        end else if (wr && hit_bank && pstrb[0]) begin
            bank_q <= pwdata[2:0];
        end
    end

    // Mask as the high byte of the status word or as its own low byte.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mask_q <= irq_pkg::MASK_RESET;
        end else if (wr && hit_status && pstrb[1]) begin
            mask_q <= pwdata[15:8];
        end else if (wr && hit_mask && pstrb[0]) begin
            mask_q <= pwdata[7:0];
        end
    end

    // Control: transmit on and the three exception source enables.
    assign tx_on_rise = wr && hit_control && pstrb[0] && pwdata[irq_pkg::B_TX_ON]
        && !control_q[irq_pkg::B_TX_ON];
    always_ff @(posedge clk) begin
        if (!rstn) begin
            control_q <= irq_pkg::CONTROL_RESET;
        end else if (wr && hit_control && pstrb[0]) begin
            control_q <= pwdata[3:0];
        end else if (tx_fatal) begin
            control_q[irq_pkg::B_TX_ON] <= 1'b0;
        end
    end
    assign transmit_on = control_q[irq_pkg::B_TX_ON];

    // Exception sources, each latched only when enabled; the set wins over its clear.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            link_pend_q <= 1'b0;
            roll_pend_q <= 1'b0;
            txerr_pend_q <= 1'b0;
        end else begin
            if (link_event && control_q[irq_pkg::B_LINK_EN]) begin
                link_pend_q <= 1'b1;
            end else if (!control_q[irq_pkg::B_LINK_EN]) begin
                link_pend_q <= 1'b0;
            end
            if (rollover_event && control_q[irq_pkg::B_ROLL_EN]) begin
                roll_pend_q <= 1'b1;
            end else if (rd && hit_counter) begin
                roll_pend_q <= 1'b0;
            end
            if (tx_fatal && control_q[irq_pkg::B_TXERR_EN]) begin
                txerr_pend_q <= 1'b1;
            end else if (tx_on_rise) begin
                txerr_pend_q <= 1'b0;
            end
        end
    end

    // Cause record for software, and a rollover counter that the counter read returns.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cause_q <= '0;
            rollover_count_q <= 8'h00;
        end else begin
            if (link_event) begin
                cause_q.link_down <= 1'b1;
            end else if (rd && hit_protocol) begin
                cause_q.link_down <= 1'b0;
            end
            if (rollover_event) begin
                cause_q.rollover <= 1'b1;
                rollover_count_q <= rollover_count_q + 8'h01;
            end else if (rd && hit_counter) begin
                cause_q.rollover <= 1'b0;
            end
            if (tx_fatal) begin
                cause_q.fault <= tx_fault;
            end
        end
    end

    // Monitored PHY bits: latch the first change and hold until read.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            phy_held_q <= '0;
            phy_pend_q <= 1'b0;
        end else if (rd && hit_phy) begin
            phy_held_q <= phy_status_live;
            phy_pend_q <= 1'b0;
        end else if (!phy_pend_q && (phy_status_live != phy_held_q)) begin
            phy_held_q <= phy_status_live;
            phy_pend_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mgmt_q <= 1'b0;
        end else if (!phy_pend_q && (phy_status_live != phy_held_q)) begin
            mgmt_q <= 1'b1;
        end else if (ack[irq_pkg::B_MGMT]) begin
            mgmt_q <= 1'b0;
        end
    end

    // Early receive: one event per packet once stored bytes exceed the limit.
    assign limit_bytes = COUNT_W_L'(early_rx_ctrl_q[irq_pkg::LIMIT_W-1:0])
        << irq_pkg::UNIT_SHIFT;
    assign over_limit = rx_event.active && (rx_event.byte_count > limit_bytes);
    always_ff @(posedge clk) begin
        if (!rstn) begin
            early_fired_q <= 1'b0;
        end else if (!rx_event.active || rx_event.ended) begin
            early_fired_q <= 1'b0;
        end else if (over_limit) begin
            early_fired_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            early_q <= 1'b0;
        end else if (over_limit && !early_fired_q) begin
            early_q <= 1'b1;
        end else if (ack[irq_pkg::B_EARLY]) begin
            early_q <= 1'b0;
        end
    end

    // Drop request acts only on a packet still in flight, then clears itself.
    assign drop_now = early_rx_ctrl_q[irq_pkg::B_DROP] && rx_event.active
        && !rx_event.ended;
    assign rx_discard = drop_now;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            early_rx_ctrl_q <= 8'h00;
        end else if (wr && hit_early && pstrb[0]) begin
            early_rx_ctrl_q <= pwdata[7:0];
        end else if (drop_now || !rx_event.active) begin
            early_rx_ctrl_q[irq_pkg::B_DROP] <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            abort_q <= 1'b0;
        end else if (drop_now || rx_event.alloc_abort || rx_event.long_abort) begin
            abort_q <= 1'b1;
        end else if (ack[irq_pkg::B_ABORT]) begin
            abort_q <= 1'b0;
        end
    end

    // Allocation result; failed reads as its complement and is high after reset.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            alloc_q <= 1'b0;
        end else if (alloc_ok) begin
            alloc_q <= 1'b1;
        end else if (alloc_request || alloc_fail) begin
            alloc_q <= 1'b0;
        end
    end
    assign alloc_failed = !alloc_q;

    // Transmit queue empty latches on the empty edge.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            txempty_q <= irq_pkg::STATUS_RESET[irq_pkg::B_TXEMPTY];
            txempty_prev_q <= 1'b1;
        end else begin
            txempty_prev_q <= tx_queue_empty;
            if (tx_queue_empty && !txempty_prev_q) begin
                txempty_q <= 1'b1;
            end else if (ack[irq_pkg::B_TXEMPTY]) begin
                txempty_q <= 1'b0;
            end
        end
    end

    // Completion acknowledge pops the head entry for one cycle.
    assign completion_pop = ack[irq_pkg::B_TXDONE] && !completion_queue_empty;

endmodule

// file: tb/cq_model.sv
// Completion queue model on the transmitter side of the block.
module cq_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Queue traffic
    input wire logic push,
    input wire logic completion_pop,
    output logic completion_queue_empty
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] count_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            count_q <= 4'h0;
        end else begin
            count_q <= count_q + 4'(push) - 4'(completion_pop && count_q != 4'h0);
        end
    end
    assign completion_queue_empty = (count_q == 4'h0);
endmodule

// file: tb/irq_checker.sv
// Port-level assertions for the interrupt status block.
module irq_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    // Far side
    input wire irq_pkg::rx_event_t rx_event,
    input wire logic rx_discard,
    input wire logic alloc_request,
    input wire logic alloc_ok,
    input wire logic alloc_fail,
    input wire logic alloc_failed,
    input wire logic completion_queue_empty,
    input wire logic completion_pop,
    input wire logic tx_fatal,
    input wire logic transmit_on,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic acc_w;
    logic ack_w;
    logic [2:0] bank_q;
    assign acc_w = psel && penable && pwrite;
    assign ack_w = acc_w && paddr == 8'h30 && bank_q == 3'h2 && pwdata[1];
    // Tracks the bank select so acknowledge writes can be recognised.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bank_q <= 3'h0;
        end else if (acc_w && paddr == 8'h38 && pstrb[0]) begin
            bank_q <= pwdata[2:0];
        end
    end
    a_pop_on_ack: assert property (ack_w && pstrb[0] && !completion_queue_empty |-> completion_pop)
        else $error("ack write did not pop");
    a_pop_cause: assert property (completion_pop |-> ack_w && !completion_queue_empty)
        else $error("pop without ack");
    a_alloc_ok: assert property (alloc_ok && !alloc_fail |=> !alloc_failed)
        else $error("alloc success not shown");
    a_alloc_fail: assert property (alloc_fail |=> alloc_failed)
        else $error("alloc fail not shown");
    a_alloc_req: assert property (alloc_request && !alloc_ok |=> alloc_failed)
        else $error("alloc flag kept on request");
    a_alloc_reset: assert property ($rose(rstn) |-> alloc_failed)
        else $error("alloc flag set after reset");
    a_fatal_off: assert property (tx_fatal && !(acc_w && paddr == 8'h40) |=> !transmit_on)
        else $error("transmit stayed on after fatal");
    a_drop_pulse: assert property (rx_discard |=> !rx_discard)
        else $error("drop did not clear itself");
    a_drop_active: assert property (rx_discard |-> rx_event.active && !rx_event.ended)
        else $error("drop outside a packet");
    a_irq_masked: assert property ($rose(rstn) |-> !irq [*2])
        else $error("irq with mask cleared");
endmodule
bind irq_status_block irq_checker u_chk (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .rx_event(rx_event), .rx_discard(rx_discard), .alloc_request(alloc_request),
    .alloc_ok(alloc_ok), .alloc_fail(alloc_fail), .alloc_failed(alloc_failed),
    .completion_queue_empty(completion_queue_empty), .completion_pop(completion_pop),
    .tx_fatal(tx_fatal), .transmit_on(transmit_on), .irq(irq));

// file: tb/irq_status_block_tb.sv
// Self-checking bench for the interrupt status block.
module irq_status_block_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, slv_q;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic [3:0] pstrb;
    irq_pkg::rx_event_t rx_ev;
    irq_pkg::tx_fault_t fault;
    logic rxq_empty, discard, a_req, a_ok, a_fail, a_failed, txq_empty, cq_empty, pop;
    logic link_ev, roll_ev, fatal, tx_on, irq, push, disc_seen;
    logic [8:0] phy;
    int err_total, checks_done;

    irq_status_block i_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_event(rx_ev), .rx_queue_empty(rxq_empty),
        .rx_discard(discard), .alloc_request(a_req), .alloc_ok(a_ok), .alloc_fail(a_fail),
        .alloc_failed(a_failed), .tx_queue_empty(txq_empty), .completion_queue_empty(cq_empty),
        .completion_pop(pop), .link_event(link_ev), .rollover_event(roll_ev),
        .tx_fatal(fatal), .tx_fault(fault), .transmit_on(tx_on), .phy_status_live(phy),
        .irq(irq));
    cq_model i_cq (.clk(clk), .rstn(rstn), .push(push), .completion_pop(pop),
        .completion_queue_empty(cq_empty));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (discard === 1'b1) begin
            disc_seen <= 1'b1;
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd_q = prdata;
        slv_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge keeps the next request off the edge that released this one.
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d}, 4'h1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        check(rd_q[7:0], exp);
    endtask

    task automatic t_reset;
        wr(8'h38, 8'h02);
        rd(8'h30, 8'h04);
        check(rd_q[15:8], 8'h00);
        rd(8'h34, 8'h00);
        apb(1'b0, 8'hFC, 32'h0000_0000, 4'h0);
        check({7'h00, slv_q}, 8'h01);
        $display("t_reset done");
    endtask
    task automatic t_mask;
        wr(8'h34, 8'h04);
        rd(8'h34, 8'h04);
        check({7'h00, irq}, 8'h01);
        wr(8'h30, 8'h00);
        wr(8'h30, 8'hFB);
        rd(8'h30, 8'h04);
        wr(8'h30, 8'h04);
        rd(8'h30, 8'h00);
        check({7'h00, irq}, 8'h00);
        txq_empty <= 1'b0;
        @(posedge clk);
        txq_empty <= 1'b1;
        @(posedge clk);
        rd(8'h30, 8'h04);
        wr(8'h30, 8'h04);
        apb(1'b1, 8'h30, 32'h0000_8000, 4'h2);
        rd(8'h34, 8'h80);
        $display("t_mask done");
    endtask
    task automatic t_txdone;
        push <= 1'b1;
        repeat (2) @(posedge clk);
        push <= 1'b0;
        rd(8'h30, 8'h02);
        wr(8'h30, 8'h02);
        rd(8'h30, 8'h02);
        wr(8'h30, 8'h02);
        rd(8'h30, 8'h00);
        $display("t_txdone done");
    endtask
    task automatic t_alloc;
        a_ok <= 1'b1;
        @(posedge clk);
        a_ok <= 1'b0;
        rd(8'h30, 8'h08);
        check({7'h00, a_failed}, 8'h00);
        a_req <= 1'b1;
        @(posedge clk);
        a_req <= 1'b0;
        rd(8'h30, 8'h00);
        $display("t_alloc done");
    endtask
    task automatic t_early;
        wr(8'h38, 8'h03);
        wr(8'h30, 8'h01);
        rx_ev.active <= 1'b1;
        rx_ev.byte_count <= 12'h040;
        wr(8'h38, 8'h02);
        rd(8'h30, 8'h00);
        rx_ev.byte_count <= 12'h041;
        @(posedge clk);
        rd(8'h30, 8'h40);
        wr(8'h30, 8'h40);
        rd(8'h30, 8'h00);
        wr(8'h38, 8'h03);
        disc_seen <= 1'b0;
        wr(8'h30, 8'h81);
        rx_ev.active <= 1'b0;
        wr(8'h38, 8'h02);
        check({7'h00, disc_seen}, 8'h01);
        rd(8'h30, 8'h10);
        wr(8'h30, 8'h10);
        rx_ev.alloc_abort <= 1'b1;
        @(posedge clk);
        rx_ev.alloc_abort <= 1'b0;
        rd(8'h30, 8'h10);
        wr(8'h30, 8'h10);
        rd(8'h30, 8'h00);
        $display("t_early done");
    endtask
    task automatic t_proto;
        wr(8'h40, 8'h02);
        link_ev <= 1'b1;
        @(posedge clk);
        link_ev <= 1'b0;
        wr(8'h30, 8'h20);
        rd(8'h30, 8'h20);
        wr(8'h40, 8'h00);
        rd(8'h30, 8'h00);
        wr(8'h40, 8'h09);
        fatal <= 1'b1;
        fault.underrun <= 1'b1;
        @(posedge clk);
        fatal <= 1'b0;
        rd(8'h30, 8'h20);
        check({7'h00, tx_on}, 8'h00);
        wr(8'h40, 8'h09);
        rd(8'h30, 8'h00);
        $display("t_proto done");
    endtask
    task automatic t_mgmt;
        phy <= 9'h101;
        @(posedge clk);
        rd(8'h30, 8'h80);
        check({7'h00, irq}, 8'h01);
        wr(8'h30, 8'h80);
        rd(8'h30, 8'h00);
        check({7'h00, irq}, 8'h00);
        $display("t_mgmt done");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        {rstn, psel, penable, pwrite, a_req, a_ok, a_fail, link_ev, roll_ev} = '0;
        {fatal, push, disc_seen} = '0;
        {rxq_empty, txq_empty} = 2'h3;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        rx_ev = '0;
        fault = '0;
        phy = 9'h000;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset;
        t_mask;
        t_txdone;
        t_alloc;
        t_early;
        t_proto;
        t_mgmt;
        summarize;
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        summarize;
    end
endmodule
